// ### src/paus_flag_cell.sv
// Purpose: One sticky status flag with write-one-to-clear.
// Assumes: Set, clear and reset requests are on sys_clk_i.
// Notes:   A set in a write-one clearing cycle keeps the flag high; clr_all_i clears it anyway.
`timescale 1ns/1ps
module paus_flag_cell (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Control
	input wire logic clr_all_i,
	input wire logic set_i,
	input wire logic w1c_i,
	// State
	output logic flag_o
);

	logic flag_nxt;

	always_comb begin
		flag_nxt = (flag_o && !w1c_i) || set_i; // RULE5 RULE19
		if (clr_all_i) begin
			flag_nxt = 1'b0; // RULE17
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_o <= 1'b0; // RULE17
		end else if (ce_i) begin
			flag_o <= flag_nxt;
		end
	end

endmodule

// ### src/paus_pkg.sv
// Purpose: Shared constants and carriers for the uncorrectable error
//          status block of an advanced error reporting capability.
// Assumes: Configuration accesses arrive as dword requests, byte address.
// Notes:   Only the capability header and the status word are held here.
package paus_pkg;

	// ==========================================================
	// Configuration space layout
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam logic [11:0] CAPID_OFS = 12'h100;
	localparam logic [11:0] NXTVER_OFS = 12'h102;
	localparam logic [11:0] UNCOR_OFS = 12'h104;

	// ==========================================================
	// Capability header values
	localparam logic [15:0] CAPID_VAL = 16'h0001;
	localparam logic [11:0] NEXT_VC_PTR = 12'h150;
	localparam logic [11:0] NEXT_END_PTR = 12'h000;
	localparam logic [3:0] CAP_VER = 4'h1;
	localparam int unsigned NXT_PTR_LSB = 4;

	// ==========================================================
	// Status bit positions
	localparam int unsigned BIT_UR = 20;
	localparam int unsigned BIT_ECRC = 19;
	localparam int unsigned BIT_MAL = 18;
	localparam int unsigned BIT_OVF = 17;
	localparam int unsigned BIT_UNXP = 16;
	localparam int unsigned BIT_CABT = 15;
	localparam int unsigned BIT_CTO = 14;
	localparam int unsigned BIT_FC = 13;
	localparam int unsigned BIT_PSN = 12;
	localparam int unsigned BIT_DLL = 4;
	localparam logic [31:0] IMPL_MASK = 32'h001FF010;
	localparam logic [31:0] UNCOR_RST = 32'h00000000;

	// ==========================================================
	// Reporting
	localparam int unsigned FEP_W = 5;
	localparam logic [4:0] FEP_RST = 5'h00;
	localparam int unsigned SYNC_STAGES = 2;

	// Error events raised by the link and transaction logic
	typedef struct packed {
		logic unsupported_request_flag;
		logic end_to_end_crc_flag;
		logic malformed_packet_flag;
		logic credit_overrun_flag;
		logic stray_completion_flag;
		logic completer_abort_flag;
		logic completion_wait_expired_flag;
		logic credit_protocol_fault_flag;
		logic poisoned_packet_flag;
		logic link_protocol_flag;
	} paus_err_evt_t;

	// One configuration request, read or write
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} paus_cfg_req_t;

endpackage

// ### src/paus_rst_merge.sv
// Purpose: Merge fundamental and global reset pins into one clear.
// Assumes: Both pins are asynchronous to sys_clk_i.
// Notes:   Power-on reset is rst_n_i itself and acts asynchronously.
`timescale 1ns/1ps
module paus_rst_merge
	import paus_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Reset pins
	input wire logic perst_n_i,
	input wire logic global_reset_input_i,
	// Merged clear
	output logic clr_o
);

	logic [SYNC_STAGES-1:0] perst_n_sync_r;
	logic [SYNC_STAGES-1:0] global_reset_input_sync_r;

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			perst_n_sync_r <= '0;
			global_reset_input_sync_r <= '0;
		end else if (ce_i) begin
			perst_n_sync_r <= {perst_n_sync_r[0], perst_n_i};
			global_reset_input_sync_r <= {global_reset_input_sync_r[0], global_reset_input_i};
		end
	end

	// Registered so downstream sees one clean level
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clr_o <= 1'b1;
		end else if (ce_i) begin
			clr_o <= !perst_n_sync_r[1] || global_reset_input_sync_r[1]; // RULE17
		end
	end

endmodule

// ### src/paus_uncor_status.sv
// Purpose: Advanced error reporting header and uncorrectable status word.
// Assumes: Events and config requests come from logic on sys_clk_i.
// Notes:   Reads answer one cycle after the request; ce_i freezes all.
//
// Contract
// [RULE1] Capability identifier reads constant 0001h
// [RULE2] Control bit low: next pointer reads 000h
// [RULE3] Control bit high: next pointer reads 150h
// [RULE4] Version nibble reads 1h; register read-only
// [RULE5] Status bit clears only on written one
// [RULE6] Reserved status bits always read zero
// [RULE7] Unsupported request sets bit 20
// [RULE8] End-to-end CRC error sets bit 19
// [RULE9] Malformed packet sets bit 18
// [RULE10] Credit overrun by partner sets bit 17
// [RULE11] Unmatched completion sets bit 16
// [RULE12] Returned completer abort sets bit 15
// [RULE13] Completion wait expiry sets bit 14
// [RULE14] Flow-control protocol fault sets bit 13
// [RULE15] Poisoned packet received sets bit 12
// [RULE16] Data link protocol error sets bit 4
// [RULE17] Fundamental, global, power-on reset clear flags
// [RULE18] Masked error: no flag, message, log, pointer
// [RULE19] Set wins over simultaneous write-one clear
`timescale 1ns/1ps
module paus_uncor_status
	import paus_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Reset pins
	input wire logic perst_n_i,
	input wire logic global_reset_input_i,
	// Control from other registers
	input wire logic vchan_structure_present_ctl_i,
	input wire logic [31:0] err_mask_i,
	// Error events
	input wire paus_err_evt_t err_evt_i,
	// Configuration access
	input wire paus_cfg_req_t cfg_req_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_ack_o,
	// Reporting
	output logic [31:0] uncor_flags_o,
	output logic err_msg_o,
	output logic hdr_log_load_o,
	output logic first_err_vld_o,
	output logic [FEP_W-1:0] first_err_ptr_o
);

	logic clr_all;
	logic [31:0] evt_vec;
	logic [31:0] set_vec;
	logic [31:0] w1c_vec;
	logic [31:0] be_mask;
	logic [31:0] cfg_rdata_nxt;
	logic [15:0] nxt_ver_word;
	logic [9:0] req_dw;
	logic hit_cap;
	logic hit_uncor;
	logic wr_uncor;
	logic any_set;
	logic [FEP_W-1:0] fep_sel;
	logic fep_clr;

	// ==========================================================
	// Reset merge
	paus_rst_merge u_rst_merge (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.perst_n_i(perst_n_i),
		.global_reset_input_i(global_reset_input_i),
		.clr_o(clr_all)
	);

	// ==========================================================
	// Event mapping
	always_comb begin
		evt_vec = '0;
		evt_vec[BIT_UR] = err_evt_i.unsupported_request_flag; // RULE7
		evt_vec[BIT_ECRC] = err_evt_i.end_to_end_crc_flag; // RULE8
		evt_vec[BIT_MAL] = err_evt_i.malformed_packet_flag; // RULE9
		evt_vec[BIT_OVF] = err_evt_i.credit_overrun_flag; // RULE10
		evt_vec[BIT_UNXP] = err_evt_i.stray_completion_flag; // RULE11
		evt_vec[BIT_CABT] = err_evt_i.completer_abort_flag; // RULE12
		evt_vec[BIT_CTO] = err_evt_i.completion_wait_expired_flag; // RULE13
		evt_vec[BIT_FC] = err_evt_i.credit_protocol_fault_flag; // RULE14
		evt_vec[BIT_PSN] = err_evt_i.poisoned_packet_flag; // RULE15
		evt_vec[BIT_DLL] = err_evt_i.link_protocol_flag; // RULE16
	end

	// Masked events never reach a flag or any report
	assign set_vec = evt_vec & ~err_mask_i & IMPL_MASK; // RULE18
	assign any_set = |set_vec;

	// ==========================================================
	// Request decode
	assign req_dw = cfg_req_i.addr[11:2];
	assign hit_cap = (req_dw == CAPID_OFS[11:2]);
	assign hit_uncor = (req_dw == UNCOR_OFS[11:2]);
	assign wr_uncor = cfg_req_i.wr && hit_uncor;

	always_comb begin
		be_mask = '0;
		for (int b = 0; b < 4; b++) begin
			be_mask[b*8 +: 8] = {8{cfg_req_i.be[b]}};
		end
	end

	// Writes to the header dword fall on read-only bits and are dropped
	assign w1c_vec = wr_uncor ?
		(cfg_req_i.wdata & be_mask & IMPL_MASK) : '0; // RULE5 RULE1

	// ==========================================================
	// Status flags
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_flag
			if (IMPL_MASK[gi]) begin : g_impl
				paus_flag_cell u_cell (
					.sys_clk_i(sys_clk_i),
					.rst_n_i(rst_n_i),
					.ce_i(ce_i),
					.clr_all_i(clr_all),
					.set_i(set_vec[gi]),
					.w1c_i(w1c_vec[gi]),
					.flag_o(uncor_flags_o[gi])
				);
			end else begin : g_rsvd
				assign uncor_flags_o[gi] = 1'b0; // RULE6
			end
		end
	endgenerate

	// ==========================================================
	// Read path
	always_comb begin
		nxt_ver_word = {NEXT_END_PTR, CAP_VER}; // RULE2 RULE4
		if (vchan_structure_present_ctl_i) begin
			nxt_ver_word = {NEXT_VC_PTR, CAP_VER}; // RULE3
		end
	end

	always_comb begin
		cfg_rdata_nxt = '0;
		if (hit_cap) begin
			cfg_rdata_nxt = {nxt_ver_word, CAPID_VAL}; // RULE1
		end else if (hit_uncor) begin
			cfg_rdata_nxt = uncor_flags_o & IMPL_MASK; // RULE6
		end
	end

	// Unmapped dwords read as zero and still acknowledge
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_rdata_o <= '0;
		end else if (ce_i) begin
			if (cfg_req_i.rd) begin
				cfg_rdata_o <= cfg_rdata_nxt;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_ack_o <= 1'b0;
		end else if (ce_i) begin
			cfg_ack_o <= cfg_req_i.rd || cfg_req_i.wr;
		end
	end

	// ==========================================================
	// Error reporting strobes
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			err_msg_o <= 1'b0;
		end else if (ce_i) begin
			err_msg_o <= any_set && !clr_all; // RULE18
		end
	end

	// Header log loads only for the error that claims the pointer
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hdr_log_load_o <= 1'b0;
		end else if (ce_i) begin
			hdr_log_load_o <= any_set && (!first_err_vld_o || fep_clr)
				&& !clr_all;
		end
	end

	// ==========================================================
	// First error pointer
	always_comb begin
		fep_sel = FEP_RST;
		for (int i = 0; i < 32; i++) begin
			if (set_vec[i]) begin
				fep_sel = FEP_W'(i);
			end
		end
	end

	// Released when software clears the bit it points at
	assign fep_clr = first_err_vld_o && w1c_vec[first_err_ptr_o];

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			first_err_vld_o <= 1'b0;
			first_err_ptr_o <= FEP_RST;
		end else if (ce_i) begin
			if (clr_all) begin
				first_err_vld_o <= 1'b0; // RULE17
				first_err_ptr_o <= FEP_RST;
			end else if (any_set && (!first_err_vld_o || fep_clr)) begin
				first_err_vld_o <= 1'b1; // RULE18
				first_err_ptr_o <= fep_sel;
			end else if (fep_clr) begin
				first_err_vld_o <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_rd_cap;
		ce_i && cfg_req_i.rd && hit_cap;
	endsequence

	sequence s_rd_uncor;
		ce_i && cfg_req_i.rd && hit_uncor;
	endsequence

	property p_sets(int b, logic ev);
		ce_i && ev && !err_mask_i[b] && !clr_all |=> uncor_flags_o[b];
	endproperty

	a_capid_const: assert property ( // RULE1
		s_rd_cap |=> cfg_ack_o && cfg_rdata_o[15:0] == 16'h0001)
		else $error("capability identifier not 0001h");

	a_next_end_ptr: assert property ( // RULE2
		s_rd_cap ##0 !vchan_structure_present_ctl_i
		|=> cfg_rdata_o[31:20] == 12'h000)
		else $error("next pointer not 000h with control low");

	a_next_vc_ptr: assert property ( // RULE3
		s_rd_cap ##0 vchan_structure_present_ctl_i
		|=> cfg_rdata_o[31:20] == 12'h150)
		else $error("next pointer not 150h with control high");

	a_cap_version: assert property ( // RULE4
		s_rd_cap |=> cfg_rdata_o[19:16] == 4'h1)
		else $error("capability version not 1h");

	a_w1c_clears: assert property ( // RULE5
		ce_i && !clr_all && uncor_flags_o[BIT_UR] && w1c_vec[BIT_UR]
		&& !set_vec[BIT_UR] |=> !uncor_flags_o[BIT_UR])
		else $error("write of one did not clear flag");

	a_zero_write_keeps: assert property ( // RULE5
		ce_i && !clr_all && wr_uncor && cfg_req_i.be[2]
		&& uncor_flags_o[BIT_UR] && !cfg_req_i.wdata[BIT_UR]
		|=> uncor_flags_o[BIT_UR])
		else $error("write of zero disturbed flag");

	a_rsvd_bits_zero: assert property ( // RULE6
		s_rd_uncor |=> (cfg_rdata_o & ~32'h001FF010) == 32'h00000000)
		else $error("reserved status bits read nonzero");

	a_ur_sets: assert property ( // RULE7
		p_sets(20, err_evt_i.unsupported_request_flag))
		else $error("unsupported request did not set bit 20");

	a_ecrc_sets: assert property ( // RULE8
		p_sets(19, err_evt_i.end_to_end_crc_flag))
		else $error("CRC error did not set bit 19");

	a_mal_sets: assert property ( // RULE9
		p_sets(18, err_evt_i.malformed_packet_flag))
		else $error("malformed packet did not set bit 18");

	a_ovf_sets: assert property ( // RULE10
		p_sets(17, err_evt_i.credit_overrun_flag))
		else $error("credit overrun did not set bit 17");

	a_unxp_sets: assert property ( // RULE11
		p_sets(16, err_evt_i.stray_completion_flag))
		else $error("stray completion did not set bit 16");

	a_cabt_sets: assert property ( // RULE12
		p_sets(15, err_evt_i.completer_abort_flag))
		else $error("completer abort did not set bit 15");

	a_cto_sets: assert property ( // RULE13
		p_sets(14, err_evt_i.completion_wait_expired_flag))
		else $error("completion expiry did not set bit 14");

	a_fc_sets: assert property ( // RULE14
		p_sets(13, err_evt_i.credit_protocol_fault_flag))
		else $error("flow-control fault did not set bit 13");

	a_psn_sets: assert property ( // RULE15
		p_sets(12, err_evt_i.poisoned_packet_flag))
		else $error("poisoned packet did not set bit 12");

	a_dll_sets: assert property ( // RULE16
		p_sets(4, err_evt_i.link_protocol_flag))
		else $error("link protocol error did not set bit 4");

	a_reset_clears: assert property ( // RULE17
		ce_i && clr_all |=> uncor_flags_o == 32'h00000000
		&& !first_err_vld_o)
		else $error("reset left a status flag set");

	a_mask_no_rise: assert property ( // RULE18
		ce_i |=> (uncor_flags_o & ~$past(uncor_flags_o)
		& ~$past(set_vec)) == 32'h00000000)
		else $error("flag rose without an unmasked event");

	a_mask_no_msg: assert property ( // RULE18
		ce_i && !any_set |=> !err_msg_o && !hdr_log_load_o)
		else $error("report raised for a masked error");

	a_set_beats_clr: assert property ( // RULE19
		ce_i && !clr_all && |(set_vec & w1c_vec)
		|=> (uncor_flags_o & $past(set_vec)) == $past(set_vec))
		else $error("simultaneous clear lost an event");

endmodule

// ### test/paus_host_model.sv
// Purpose: Behavioural host issuing configuration reads and writes.
// Assumes: One request per call; the answer is awaited under a bound.
// Notes:   Idle cycles carry junk address and data to expose bad decode.
`timescale 1ns/1ps
module paus_host_model
	import paus_pkg::*;
(
	// Clock
	input wire logic sys_clk_i,
	// Answer
	input wire logic cfg_ack_i,
	input wire logic [31:0] cfg_rdata_i,
	// Request
	output paus_cfg_req_t cfg_req_o
);
	// ==========================================================
	// Request driving
	initial cfg_req_o = '0;

	task automatic idle();
		cfg_req_o <= '{rd: 1'b0, wr: 1'b0, addr: 12'($urandom),
			be: 4'($urandom), wdata: $urandom};
	endtask

	task automatic issue(input logic r, input logic [11:0] a,
		input logic [3:0] b, input logic [31:0] w, output logic [31:0] d);
		int n;
		@(posedge sys_clk_i);
		cfg_req_o <= '{rd: r, wr: ~r, addr: a, be: b, wdata: w};
		@(posedge sys_clk_i);
		idle();
		n = 0;
		while (cfg_ack_i !== 1'b1 && n < 8) begin
			@(posedge sys_clk_i);
			n++;
		end
		// A missing answer shows up as all ones
		d = (n < 8) ? cfg_rdata_i : 32'hFFFFFFFF;
	endtask

	task automatic cfg_rd(input logic [11:0] a, output logic [31:0] d);
		issue(1'b1, a, 4'hF, 32'h00000000, d);
	endtask

	task automatic cfg_wr(input logic [11:0] a, input logic [3:0] b,
		input logic [31:0] w);
		logic [31:0] j;
		issue(1'b0, a, b, w, j);
	endtask
endmodule

// ### test/paus_uncor_status_tb.sv
// Purpose: Self-checking bench for the uncorrectable status block.
// Assumes: ce_i held high outside the enable test; the host model owns the config request.
// Notes:   Random phase models flags and message pulses per cycle.
`timescale 1ns/1ps
module paus_uncor_status_tb
	import paus_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ce = 1'b1;
	logic perst_n_i = 1'b1;
	logic global_reset_input = 1'b0;
	logic vchan = 1'b0;
	logic [31:0] err_mask = '0;
	paus_err_evt_t err_evt = '0;
	paus_cfg_req_t cfg_req;
	logic [31:0] cfg_rdata;
	logic cfg_ack;
	logic [31:0] flags;
	logic err_msg;
	logic hdr_load;
	logic fe_vld;
	logic [FEP_W-1:0] fe_ptr;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;

	always #20 sys_clk_i = ~sys_clk_i;

	paus_uncor_status dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.ce_i(ce), .perst_n_i(perst_n_i), .global_reset_input_i(global_reset_input),
		.vchan_structure_present_ctl_i(vchan), .err_mask_i(err_mask),
		.err_evt_i(err_evt), .cfg_req_i(cfg_req), .cfg_rdata_o(cfg_rdata),
		.cfg_ack_o(cfg_ack), .uncor_flags_o(flags), .err_msg_o(err_msg),
		.hdr_log_load_o(hdr_load), .first_err_vld_o(fe_vld),
		.first_err_ptr_o(fe_ptr));

	paus_host_model host (.sys_clk_i(sys_clk_i), .cfg_ack_i(cfg_ack),
		.cfg_rdata_i(cfg_rdata), .cfg_req_o(cfg_req));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] evt_bits(paus_err_evt_t e);
		return {11'h000, e[9:1], 7'h00, e[0], 4'h0};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic pulse(input paus_err_evt_t e, input logic [31:0] m);
		@(posedge sys_clk_i);
		err_evt <= e;
		err_mask <= m;
		@(posedge sys_clk_i);
		err_evt <= '0;
		#1;
	endtask

	// Hang guard, far above the fewer than one thousand cycles the run needs
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [31:0] eb;
		logic [31:0] exp;
		logic [31:0] v;
		logic msg;
		paus_err_evt_t ev;
		paus_err_evt_t cur;
		logic [31:0] cm;
		int p;
		void'($urandom(54));
		repeat (5) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		host.cfg_rd(CAPID_OFS, d);
		chk(d, 32'h00010001);
		host.cfg_rd(NXTVER_OFS, d);
		chk(d, 32'h00010001);
		@(posedge sys_clk_i);
		vchan <= 1'b1;
		host.cfg_rd(CAPID_OFS, d);
		chk(d, 32'h15010001);
		host.cfg_wr(CAPID_OFS, 4'hF, 32'h00000000);
		host.cfg_rd(CAPID_OFS, d);
		chk(d, 32'h15010001);
		host.cfg_rd(12'h200, d);
		chk(d, 32'h00000000);
		$display("test header done");

		for (int i = 0; i < 10; i++) begin
			ev = paus_err_evt_t'(10'h001 << i);
			eb = evt_bits(ev);
			p = (i == 0) ? 4 : i + 11;
			pulse(ev, eb);
			chk(flags, 32'h00000000);
			chk(err_msg, 1'b0);
			pulse(ev, 32'h00000000);
			chk(flags, eb);
			chk(err_msg, 1'b1);
			chk(hdr_load, 1'b1);
			chk(fe_vld, 1'b1);
			chk(fe_ptr, p);
			host.cfg_rd(UNCOR_OFS, d);
			chk(d, eb);
			host.cfg_wr(UNCOR_OFS, 4'h0, 32'hFFFFFFFF);
			host.cfg_wr(UNCOR_OFS, 4'hF, ~eb);
			chk(flags, eb);
			host.cfg_wr(UNCOR_OFS, 4'hF, eb);
			chk(flags, 32'h00000000);
			chk(fe_vld, 1'b0);
		end
		$display("test events done");

		pulse(10'h200, 32'h00000000);
		fork
			host.cfg_wr(UNCOR_OFS, 4'hF, 32'h00100000);
			pulse(10'h200, 32'h00000000);
		join
		chk(flags, 32'h00100000);
		chk(hdr_load, 1'b1);
		chk(fe_ptr, 32'h00000014);
		host.cfg_wr(UNCOR_OFS, 4'hF, 32'hFFFFFFFF);
		$display("test collision done");

		// Clock enable low must keep an unsupported request from setting bit 20 or the message
		@(posedge sys_clk_i);
		ce <= 1'b0;
		pulse(10'h200, 32'h00000000);
		chk(flags, 32'h00000000);
		chk(err_msg, 1'b0);
		@(posedge sys_clk_i);
		ce <= 1'b1;
		$display("test enable done");

		exp = '0;
		cur = '0;
		cm = '0;
		repeat (400) begin
			@(posedge sys_clk_i);
			v = evt_bits(cur) & ~cm & IMPL_MASK;
			exp = exp | v;
			msg = |v;
			cur = paus_err_evt_t'(10'($urandom & $urandom & $urandom));
			cm = $urandom & $urandom;
			err_evt <= cur;
			err_mask <= cm;
			#1;
			chk(flags, exp);
			chk(err_msg, msg);
		end
		// Quiet the events, then wipe what the random phase left behind
		@(posedge sys_clk_i);
		err_evt <= '0;
		err_mask <= '0;
		host.cfg_wr(UNCOR_OFS, 4'hF, 32'hFFFFFFFF);
		chk(flags, 32'h00000000);
		$display("test random done");

		for (int k = 0; k < 3; k++) begin
			pulse(10'h201, 32'h00000000);
			chk(flags, 32'h00100010);
			@(posedge sys_clk_i);
			case (k)
				0: perst_n_i <= 1'b0;
				1: global_reset_input <= 1'b1;
				default: rst_n_i <= 1'b0;
			endcase
			pulse(10'h201, 32'h00000000);
			repeat (3) @(posedge sys_clk_i);
			chk(flags, 32'h00000000);
			perst_n_i <= 1'b1;
			global_reset_input <= 1'b0;
			rst_n_i <= 1'b1;
			repeat (5) @(posedge sys_clk_i);
			#1;
			chk(flags, 32'h00000000);
			chk(fe_vld, 1'b0);
		end
		$display("test resets done");
		final_report();
	end
endmodule
